/* File: port_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module port_ctrl (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // port pins
    input wire logic [7:0] portb_pin_in,
    input wire logic [7:0] portc_pin_in,
    // pad controls and interrupt
    output port_ctrl_pkg::pad_ctrl_t portb_pad,
    output port_ctrl_pkg::pad_ctrl_t portc_pad,
    output logic portb_irq
);
    // ==========================================
    // registers
    logic [7:0] portb_drive_select_reg; // drive strength per pin
    logic [7:0] portc_pull_enable_reg; // pull-up enable per pin
    logic [7:0] portc_slew_enable_reg; // slew control per pin
    logic [7:0] dir_b_reg; // port b direction, 1 output
    logic [7:0] dir_c_reg; // port c direction, 1 output
    logic [7:0] portb_edge_select_reg; // polarity per pin
    logic [7:0] pin_sel_reg; // pin interrupt select
    logic portb_irq_flag_reg; // detected event
    logic portb_irq_enable_reg; // request enable
    logic portb_detect_mode_reg; // 0 edges, 1 edges and levels
    port_ctrl_pkg::apb_state_t state_reg;
    logic edge_hit;
    logic level_active;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic [31:0] rd_next;

    // address decode used for mapping checks
    function automatic logic is_mapped(input logic [7:0] a);
        case (a)
            port_ctrl_pkg::ADDR_DRIVE, port_ctrl_pkg::ADDR_IRQSC,
            port_ctrl_pkg::ADDR_PULL, port_ctrl_pkg::ADDR_SLEW,
            port_ctrl_pkg::ADDR_DIR_B, port_ctrl_pkg::ADDR_DIR_C,
            port_ctrl_pkg::ADDR_EDGE_B, port_ctrl_pkg::ADDR_PINSEL_B,
            port_ctrl_pkg::ADDR_PINS: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction

    // ==========================================
    // detector instance
    pin_detect u_detect (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(portb_pin_in),
        .pin_sel(pin_sel_reg),
        .edge_sel(portb_edge_select_reg),
        .level_mode(portb_detect_mode_reg),
        .edge_hit(edge_hit),
        .level_active(level_active)
    );

    // ==========================================
    // apb: one wait state, answer in second access cycle
    assign addr_ok = is_mapped(paddr);
    assign wr_en = psel & penable & pwrite & (state_reg == port_ctrl_pkg::ST_ACCESS);
    assign rd_en = psel & penable & ~pwrite & (state_reg == port_ctrl_pkg::ST_ACCESS);

    // access phase sequencing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= port_ctrl_pkg::ST_IDLE;
        end else begin
            case (state_reg)
                port_ctrl_pkg::ST_IDLE: begin
                    if (psel & penable) begin
                        state_reg <= port_ctrl_pkg::ST_ACCESS;
                    end
                end
                port_ctrl_pkg::ST_ACCESS: begin
                    state_reg <= port_ctrl_pkg::ST_IDLE;
                end
                default: begin
                    state_reg <= port_ctrl_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // pready and error, registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & penable & (state_reg == port_ctrl_pkg::ST_IDLE) & ~pready;
            pslverr <= psel & penable & (state_reg == port_ctrl_pkg::ST_IDLE) & ~pready
                & ~addr_ok;
        end
    end

    // read mux
    always_comb begin
        rd_next = port_ctrl_pkg::RD_ZERO;
        case (paddr)
            port_ctrl_pkg::ADDR_DRIVE: rd_next[7:0] = portb_drive_select_reg;
            port_ctrl_pkg::ADDR_IRQSC: begin
                rd_next[port_ctrl_pkg::BIT_FLAG] = portb_irq_flag_reg;
                rd_next[port_ctrl_pkg::BIT_ACK] = 1'b0;
                rd_next[port_ctrl_pkg::BIT_IE] = portb_irq_enable_reg;
                rd_next[port_ctrl_pkg::BIT_MOD] = portb_detect_mode_reg;
            end
            port_ctrl_pkg::ADDR_PULL: rd_next[7:0] = portc_pull_enable_reg;
            port_ctrl_pkg::ADDR_SLEW: rd_next[7:0] = portc_slew_enable_reg;
            port_ctrl_pkg::ADDR_DIR_B: rd_next[7:0] = dir_b_reg;
            port_ctrl_pkg::ADDR_DIR_C: rd_next[7:0] = dir_c_reg;
            port_ctrl_pkg::ADDR_EDGE_B: rd_next[7:0] = portb_edge_select_reg;
            port_ctrl_pkg::ADDR_PINSEL_B: rd_next[7:0] = pin_sel_reg;
            port_ctrl_pkg::ADDR_PINS: rd_next[15:0] = {portc_pin_in, portb_pin_in};
            default: rd_next = port_ctrl_pkg::RD_ZERO;
        endcase
    end

    // read data register, loaded with pready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= port_ctrl_pkg::RD_ZERO;
        end else if (psel & penable & ~pwrite & (state_reg == port_ctrl_pkg::ST_IDLE)) begin
            prdata <= rd_next;
        end
    end

    // ==========================================
    // plain configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            portb_drive_select_reg <= port_ctrl_pkg::RST_BYTE;
            portc_pull_enable_reg <= port_ctrl_pkg::RST_BYTE;
            portc_slew_enable_reg <= port_ctrl_pkg::RST_BYTE;
            dir_b_reg <= port_ctrl_pkg::RST_BYTE;
            dir_c_reg <= port_ctrl_pkg::RST_BYTE;
            portb_edge_select_reg <= port_ctrl_pkg::RST_BYTE;
            pin_sel_reg <= port_ctrl_pkg::RST_BYTE;
        end else if (wr_en) begin
            case (paddr)
                port_ctrl_pkg::ADDR_DRIVE: portb_drive_select_reg <= pwdata[7:0];
                port_ctrl_pkg::ADDR_PULL: portc_pull_enable_reg <= pwdata[7:0];
                port_ctrl_pkg::ADDR_SLEW: portc_slew_enable_reg <= pwdata[7:0];
                port_ctrl_pkg::ADDR_DIR_B: dir_b_reg <= pwdata[7:0];
                port_ctrl_pkg::ADDR_DIR_C: dir_c_reg <= pwdata[7:0];
                port_ctrl_pkg::ADDR_EDGE_B: portb_edge_select_reg <= pwdata[7:0];
                port_ctrl_pkg::ADDR_PINSEL_B: pin_sel_reg <= pwdata[7:0];
                default: begin
                end
            endcase
        end
    end

    // enable and mode bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            portb_irq_enable_reg <= 1'b0;
            portb_detect_mode_reg <= 1'b0;
        end else if (wr_en && paddr == port_ctrl_pkg::ADDR_IRQSC) begin
            portb_irq_enable_reg <= pwdata[port_ctrl_pkg::BIT_IE];
            portb_detect_mode_reg <= pwdata[port_ctrl_pkg::BIT_MOD];
        end
    end

    // ==========================================
    // interrupt flag: set wins over ack
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            portb_irq_flag_reg <= 1'b0;
        end else if (edge_hit | level_active) begin
            portb_irq_flag_reg <= 1'b1;
        end else if (wr_en && paddr == port_ctrl_pkg::ADDR_IRQSC
            && pwdata[port_ctrl_pkg::BIT_ACK]) begin
            portb_irq_flag_reg <= 1'b0;
        end
    end

    // request output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            portb_irq <= 1'b0;
        end else begin
            portb_irq <= portb_irq_flag_reg & portb_irq_enable_reg;
        end
    end

    // ==========================================
    // pad controls, qualified by direction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            portb_pad <= '0;
            portc_pad <= '0;
        end else begin
            portb_pad.high_drive <= portb_drive_select_reg & dir_b_reg;
            portb_pad.pull_up <= port_ctrl_pkg::RST_BYTE;
            portb_pad.pull_down <= pin_sel_reg & portb_edge_select_reg & ~dir_b_reg;
            portb_pad.slew <= port_ctrl_pkg::RST_BYTE;
            portc_pad.pull_up <= portc_pull_enable_reg & ~dir_c_reg;
            portc_pad.pull_down <= port_ctrl_pkg::RST_BYTE;
            portc_pad.high_drive <= port_ctrl_pkg::RST_BYTE;
            portc_pad.slew <= portc_slew_enable_reg & dir_c_reg;
        end
    end

    // ==========================================
    // checks: bus handshake
    // ready is a one-cycle pulse
    a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready) else $error("ready longer than one cycle");
    // error only ever marks an answered transfer
    a_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready) else $error("error without ready");
    // a read is answered in its second access cycle
    a_read_answer: assert property (@(posedge pclk) disable iff (!presetn)
        rd_en |-> pready) else $error("read not answered");
    // a write lands in the cycle that ready stands
    a_write_answer: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en |-> pready) else $error("write not answered");
    // unmapped addresses answer with an error
    a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && !addr_ok) |-> pslverr) else $error("no error on unmapped address");
    // mapped addresses never answer with an error
    a_mapped_ok: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && addr_ok) |-> !pslverr) else $error("error on mapped address");

    // ==========================================
    // checks: interrupt flag
    // an enabled pin edge sets the flag
    a_flag_set_edge: assert property (@(posedge pclk) disable iff (!presetn)
        edge_hit |=> portb_irq_flag_reg) else $error("flag not set on edge");
    // an active level sets the flag in level mode
    a_flag_set_level: assert property (@(posedge pclk) disable iff (!presetn)
        level_active |=> portb_irq_flag_reg) else $error("flag not set on level");
    // ack with no pending event clears the flag
    a_ack_clears: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == port_ctrl_pkg::ADDR_IRQSC && pwdata[port_ctrl_pkg::BIT_ACK]
        && !edge_hit && !level_active) |=> !portb_irq_flag_reg)
        else $error("ack did not clear flag");
    // nothing but an event sets the flag
    a_flag_no_write: assert property (@(posedge pclk) disable iff (!presetn)
        (!portb_irq_flag_reg && !edge_hit && !level_active) |=> !portb_irq_flag_reg)
        else $error("flag set without event");
    // a write without ack leaves the flag alone
    a_flag_write_kept: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == port_ctrl_pkg::ADDR_IRQSC && !pwdata[port_ctrl_pkg::BIT_ACK])
        |=> portb_irq_flag_reg == $past(portb_irq_flag_reg | edge_hit | level_active))
        else $error("flag changed by write");
    // in level mode, ack fails while a selected pin is still active
    a_level_holds: assert property (@(posedge pclk) disable iff (!presetn)
        (level_active && portb_irq_flag_reg) |=> portb_irq_flag_reg)
        else $error("flag lost while level active");
    // edge mode never reports levels
    a_edge_mode: assert property (@(posedge pclk) disable iff (!presetn)
        !portb_detect_mode_reg |-> !level_active) else $error("level in edge mode");
    // ack bit reads back as zero
    a_ack_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && !pwrite && paddr == port_ctrl_pkg::ADDR_IRQSC)
        |-> !prdata[port_ctrl_pkg::BIT_ACK]) else $error("ack read one");

    // ==========================================
    // checks: interrupt request
    // request mirrors flag and enable one cycle late
    a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 portb_irq == $past(portb_irq_flag_reg & portb_irq_enable_reg))
        else $error("irq mismatch");
    // disabled requests stay low
    a_irq_enable_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (!portb_irq_enable_reg) |=> !portb_irq) else $error("irq while disabled");
    // a pending enabled flag raises the request
    a_irq_raised: assert property (@(posedge pclk) disable iff (!presetn)
        (portb_irq_flag_reg && portb_irq_enable_reg) |=> portb_irq)
        else $error("irq not raised");
    // enable bit loads from the written word
    a_enable_load: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == port_ctrl_pkg::ADDR_IRQSC)
        |=> portb_irq_enable_reg == $past(pwdata[port_ctrl_pkg::BIT_IE]))
        else $error("enable not loaded");
    // mode bit loads from the written word
    a_mode_load: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == port_ctrl_pkg::ADDR_IRQSC)
        |=> portb_detect_mode_reg == $past(pwdata[port_ctrl_pkg::BIT_MOD]))
        else $error("mode not loaded");

    // ==========================================
    // checks: pad controls
    // high drive follows the select bit on outputs
    a_drive_output: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 portb_pad.high_drive == $past(portb_drive_select_reg & dir_b_reg))
        else $error("drive not applied");
    // drive select ignored on input pins
    a_drive_input: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 (portb_pad.high_drive & ~$past(dir_b_reg)) == 8'h00)
        else $error("drive on input pin");
    // pull-up follows the enable bit on inputs
    a_pull_input: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 portc_pad.pull_up == $past(portc_pull_enable_reg & ~dir_c_reg))
        else $error("pull-up not applied");
    // output pins keep their pulls off
    a_pull_output: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 (portc_pad.pull_up & $past(dir_c_reg)) == 8'h00)
        else $error("pull on output pin");
    // port c never pulls down
    a_pull_down_c: assert property (@(posedge pclk) disable iff (!presetn)
        portc_pad.pull_down == 8'h00) else $error("pull-down on port c");
    // pull-downs only on selected rising-edge inputs
    a_pull_down_b: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 portb_pad.pull_down == $past(pin_sel_reg & portb_edge_select_reg & ~dir_b_reg))
        else $error("pull-down misapplied");
    // slew follows the enable bit on outputs
    a_slew_output: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 portc_pad.slew == $past(portc_slew_enable_reg & dir_c_reg))
        else $error("slew not applied");
    // slew select ignored on input pins
    a_slew_input: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 (portc_pad.slew & ~$past(dir_c_reg)) == 8'h00)
        else $error("slew on input pin");
endmodule
`default_nettype wire

/* File: port_ctrl_pkg.sv */
package port_ctrl_pkg;
    // ==========================================
    // register map (byte addresses, one word each)
    localparam logic [7:0] ADDR_DRIVE = 8'h00;
    localparam logic [7:0] ADDR_IRQSC = 8'h04;
    localparam logic [7:0] ADDR_PULL = 8'h08;
    localparam logic [7:0] ADDR_SLEW = 8'h0C;
    localparam logic [7:0] ADDR_DIR_B = 8'h10;
    localparam logic [7:0] ADDR_DIR_C = 8'h14;
    localparam logic [7:0] ADDR_EDGE_B = 8'h18;
    localparam logic [7:0] ADDR_PINSEL_B = 8'h1C;
    localparam logic [7:0] ADDR_PINS = 8'h20;
    // ==========================================
    // status/control field positions
    localparam int BIT_FLAG = 3;
    localparam int BIT_ACK = 2;
    localparam int BIT_IE = 1;
    localparam int BIT_MOD = 0;
    // ==========================================
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_NIB = 4'h0;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;
    // pad controls for one port
    typedef struct packed {
        logic [7:0] pull_up;
        logic [7:0] pull_down;
        logic [7:0] high_drive;
        logic [7:0] slew;
    } pad_ctrl_t;
    // apb access phase states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACCESS = 2'b01
    } apb_state_t;
endpackage

/* File: pin_detect.sv */
`timescale 1ns/1ps
`default_nettype none
// per-pin edge/level detector for the interrupt pins
module pin_detect (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // pin levels and configuration
    input wire logic [7:0] pin_in,
    input wire logic [7:0] pin_sel,
    input wire logic [7:0] edge_sel,
    input wire logic level_mode,
    // detection results
    output logic edge_hit,
    output logic level_active
);
    // ==========================================
    // previous sample of the pins
    logic [7:0] prev_reg;
    logic [7:0] act_now;
    logic [7:0] act_prev;

    // pin polarity: edge_sel 1 means rising/high
    assign act_now = ~(pin_in ^ edge_sel);
    assign act_prev = ~(prev_reg ^ edge_sel);

    // remember pin levels
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_reg <= port_ctrl_pkg::RST_BYTE;
        end else begin
            prev_reg <= pin_in;
        end
    end

    // edge: enabled pin newly at active level
    assign edge_hit = |(pin_sel & act_now & ~act_prev);
    // level: enabled pin still active, only in level mode
    assign level_active = level_mode & |(pin_sel & act_now);
endmodule
`default_nettype wire

/* File: pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// external pins of ports b and c
module pin_model (
    // clock
    input wire logic pclk,
    // pad controls from the block
    input wire port_ctrl_pkg::pad_ctrl_t pb_pad,
    input wire port_ctrl_pkg::pad_ctrl_t pc_pad,
    // external drivers set by the bench
    input wire logic [7:0] drv_en_b,
    input wire logic [7:0] drv_val_b,
    input wire logic [7:0] drv_en_c,
    input wire logic [7:0] drv_val_c,
    // resolved pin levels
    output logic [7:0] pb_pin,
    output logic [7:0] pc_pin
);
    // undriven, unpulled pins wander: toggle every cycle
    logic [7:0] float_lvl = 8'h55;
    always_ff @(posedge pclk) begin
        float_lvl <= ~float_lvl;
    end
    // driver wins, then pull-up, then pull-down, else floating
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pb_pin[i] = drv_en_b[i] ? drv_val_b[i] : pb_pad.pull_up[i] ? 1'b1 :
                        pb_pad.pull_down[i] ? 1'b0 : float_lvl[i];
            pc_pin[i] = drv_en_c[i] ? drv_val_c[i] : pc_pad.pull_up[i] ? 1'b1 :
                        pc_pad.pull_down[i] ? 1'b0 : float_lvl[i];
        end
    end
endmodule
`default_nettype wire

/* File: tb_port_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// bench for the port pad and pin interrupt block
module tb_port_ctrl;
    // apb side
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, portb_irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    // pins and pads
    logic [7:0] pb_pin, pc_pin, drv_en_b, drv_val_b;
    logic [7:0] drv_en_c, drv_val_c;
    // raw transfer results
    logic [31:0] rdat;
    logic rerr;
    port_ctrl_pkg::pad_ctrl_t pb_pad, pc_pad;
    // score keeping
    int num_errors = 0;
    int checks_done = 0;
    // ==========================================
    // clock, design and partner
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    port_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .portb_pin_in(pb_pin), .portc_pin_in(pc_pin),
        .portb_pad(pb_pad), .portc_pad(pc_pad), .portb_irq(portb_irq));
    pin_model pins (.pclk(pclk), .pb_pad(pb_pad), .pc_pad(pc_pad), .drv_en_b(drv_en_b),
        .drv_val_b(drv_val_b), .drv_en_c(drv_en_c), .drv_val_c(drv_val_c), .pb_pin(pb_pin),
        .pc_pin(pc_pin));
    // ==========================================
    // helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one apb transfer: setup, access, wait for pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rdata, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            num_errors++;
            report_and_stop();
        end
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, {24'h000000, d}, r, e);
        repeat (2) @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic exp_err);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk(r, {24'h000000, exp});
        chk({31'h0, e}, {31'h0, exp_err});
    endtask
    task automatic report_and_stop;
        if (num_errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // watchdog against a hung handshake
    initial begin
        #50us;
        num_errors++;
        report_and_stop();
    end
    // ==========================================
    // main sequence
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite} = 3'b000;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        drv_en_b = 8'h01;
        drv_val_b = 8'h00;
        drv_en_c = 8'h00;
        drv_val_c = 8'h00;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        chk(pb_pad, 32'h0000_0000);
        chk(pc_pad, 32'h0000_0000);
        for (int i = 0; i < 8; i++) rd(8'(i * 4), 8'h00, 1'b0);
        rd(8'h24, 8'h00, 1'b1);
        // drive strength only on outputs
        wr(port_ctrl_pkg::ADDR_DRIVE, 8'hFF);
        wr(port_ctrl_pkg::ADDR_DIR_B, 8'h0F);
        chk(32'(pb_pad.high_drive), 32'h0000_000F);
        rd(port_ctrl_pkg::ADDR_DRIVE, 8'hFF, 1'b0);
        wr(port_ctrl_pkg::ADDR_DIR_B, 8'h00);
        chk(32'(pb_pad.high_drive), 32'h0000_0000);
        // pull-ups only on inputs, slew only on outputs
        wr(port_ctrl_pkg::ADDR_PULL, 8'hA5);
        wr(port_ctrl_pkg::ADDR_SLEW, 8'h3C);
        wr(port_ctrl_pkg::ADDR_DIR_C, 8'h0F);
        chk(32'(pc_pad.pull_up), 32'h0000_00A0);
        chk(32'(pc_pad.pull_down), 32'h0000_0000);
        chk(32'(pc_pad.slew), 32'h0000_000C);
        // edge mode, enabled, rising edge on pin 0
        wr(port_ctrl_pkg::ADDR_IRQSC, 8'h02);
        wr(port_ctrl_pkg::ADDR_PINSEL_B, 8'h01);
        wr(port_ctrl_pkg::ADDR_EDGE_B, 8'h01);
        chk(32'(pb_pad.pull_down), 32'h0000_0001);
        rd(port_ctrl_pkg::ADDR_IRQSC, 8'h02, 1'b0);
        drv_val_b <= 8'h01;
        repeat (4) @(posedge pclk);
        chk(32'(portb_irq), 32'h0000_0001);
        rd(port_ctrl_pkg::ADDR_IRQSC, 8'h0A, 1'b0);
        wr(port_ctrl_pkg::ADDR_IRQSC, 8'h06);
        rd(port_ctrl_pkg::ADDR_IRQSC, 8'h02, 1'b0);
        chk(32'(portb_irq), 32'h0000_0000);
        // level mode: pin still high so ack fails
        wr(port_ctrl_pkg::ADDR_IRQSC, 8'h03);
        rd(port_ctrl_pkg::ADDR_IRQSC, 8'h0B, 1'b0);
        wr(port_ctrl_pkg::ADDR_IRQSC, 8'h07);
        rd(port_ctrl_pkg::ADDR_IRQSC, 8'h0B, 1'b0);
        drv_val_b <= 8'h00;
        repeat (2) @(posedge pclk);
        wr(port_ctrl_pkg::ADDR_IRQSC, 8'h07);
        rd(port_ctrl_pkg::ADDR_IRQSC, 8'h03, 1'b0);
        // disabled request, flag still sets
        wr(port_ctrl_pkg::ADDR_IRQSC, 8'h00);
        drv_val_b <= 8'h01;
        repeat (4) @(posedge pclk);
        chk(32'(portb_irq), 32'h0000_0000);
        wr(port_ctrl_pkg::ADDR_IRQSC, 8'h00);
        rd(port_ctrl_pkg::ADDR_IRQSC, 8'h08, 1'b0);
        wr(port_ctrl_pkg::ADDR_IRQSC, 8'h02);
        chk(32'(portb_irq), 32'h0000_0001);
        wr(port_ctrl_pkg::ADDR_IRQSC, 8'h04);
        rd(port_ctrl_pkg::ADDR_IRQSC, 8'h00, 1'b0);
        chk(32'(portb_irq), 32'h0000_0000);
        // pin levels: port c pins 5 and 7 held up only by their pull-ups
        drv_en_b <= 8'hFF;
        drv_val_b <= 8'h5A;
        drv_en_c <= 8'h5F;
        repeat (2) @(posedge pclk);
        apb(1'b0, port_ctrl_pkg::ADDR_PINS, 32'h0000_0000, rdat, rerr);
        chk(rdat, 32'h0000_A05A);
        chk(32'(rerr), 32'h0000_0000);
        report_and_stop();
    end
endmodule
`default_nettype wire
